// *** apt_ctrl.sv ***
`include "apt_regs.svh"

module apt_ctrl (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Converter
  output logic analog_power_o,
  output logic conv_req_o,
  output logic [3:0] conv_slot_o,
  input wire logic conv_done_i,
  input wire logic [9:0] conv_data_i,
  // Processor state
  input wire logic cpu_wait_i,
  // Trigger sources
  input wire logic [15:0] analog_pin_i,
  input wire logic [3:0] dedicated_trigger_i,
  output logic [15:0] digital_input_enable_o,
  // Interrupt
  output logic irq_o
);
  import apt_pkg::*;

  // Bus state.
  logic pready_next;
  logic pslverr_next;
  logic [31:0] prdata_next;
  logic access;
  logic done;
  logic wr;
  logic rd;
  logic mapped;
  logic res_hit;
  logic [3:0] res_idx;
  logic [9:0] res_data;

  // Register state.
  apt_ctrl_s ctrl_reg;
  apt_ctrl_s ctrl_next;
  apt_trig_sel_s trig_reg;
  apt_trig_sel_s trig_next;
  logic [2:0] ist_reg;
  logic [2:0] ist_next;
  logic [2:0] imask_reg;
  logic [2:0] imask_next;
  logic [2:0] events;

  // Flag state.
  logic [15:0] conv_flag_reg;
  logic [15:0] conv_flag_next;
  logic seq_done_reg;
  logic seq_done_next;
  logic armed_reg;
  logic armed_next;

  // Sequencer state.
  apt_seq_e state_reg;
  apt_seq_e state_next;
  logic [3:0] count_reg;
  logic [3:0] count_next;
  logic [3:0] done_cnt_reg;
  logic [3:0] done_cnt_next;
  logic abort;
  logic start;
  logic ext_start;
  logic halt;
  logic fire;
  logic seq_end;
  apt_conv_res_s mem_wr;

  // Output state.
  logic power_next;
  logic req_next;
  logic [3:0] slot_next;
  logic [15:0] dien_next;
  logic irq_next;

  apt_result_mem u_mem (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .wr_i(mem_wr),
    .rd_addr_i(res_idx),
    .rd_data_o(res_data)
  );

  apt_trigger u_trig (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .sel_i(trig_reg),
    .level_i(ctrl_reg.trigger_level_not_edge),
    .polarity_i(ctrl_reg.trigger_polarity),
    .analog_pin_i(analog_pin_i),
    .dedicated_trigger_i(dedicated_trigger_i),
    .fire_o(fire)
  );

  // Every transfer takes one wait state so result memory data can be registered.
  always_comb begin
    access = psel_i & penable_i;
    done = access & pready_o;
    wr = done & pwrite_i;
    rd = done & ~pwrite_i;
    res_hit = apt_is_result(paddr_i);
    res_idx = paddr_i[5:2];
    mapped = res_hit || paddr_i == `APT_OFF_CTRL || paddr_i == `APT_OFF_TRIG
      || paddr_i == `APT_OFF_START || paddr_i == `APT_OFF_SEQ
      || paddr_i == `APT_OFF_FLAGS || paddr_i == `APT_OFF_IST
      || paddr_i == `APT_OFF_IMASK;
    pready_next = access & ~pready_o;
    pslverr_next = access & ~pready_o & ~mapped;
    prdata_next = prdata_o;
    if (access && !pready_o) begin
      prdata_next = 32'h0000_0000;
      if (res_hit) begin
        prdata_next = {22'h00_0000, res_data};
      end else begin
        unique case (paddr_i)
          `APT_OFF_CTRL: prdata_next = {24'h00_0000, ctrl_reg[7:1],
            ctrl_reg.sequence_done_irq_enable & seq_done_reg};
          `APT_OFF_TRIG: prdata_next = {24'h00_0000, trig_reg.trigger_source_kind_select,
            3'h0, trig_reg.trigger_channel_select};
          `APT_OFF_START: prdata_next = {31'h0000_0000, state_reg != seq_idle};
          `APT_OFF_SEQ: prdata_next = {24'h00_0000, seq_done_reg, 3'h0, count_reg};
          `APT_OFF_FLAGS: prdata_next = {16'h0000, conv_flag_reg};
          `APT_OFF_IST: prdata_next = {29'h0000_0000, ist_reg};
          `APT_OFF_IMASK: prdata_next = {29'h0000_0000, imask_reg};
          default: prdata_next = 32'h0000_0000;
        endcase
      end
    end
  end

  // Writes to the control, trigger select and start words all abort, so software can
  // always bring the sequencer back to a known slot before it reconfigures anything.
  always_comb begin
    ctrl_next = ctrl_reg;
    trig_next = trig_reg;
    imask_next = imask_reg;
    if (wr && paddr_i == `APT_OFF_CTRL) begin
      ctrl_next = {pwdata_i[7:1], 1'b0};
    end
    if (wr && paddr_i == `APT_OFF_TRIG) begin
      trig_next = {pwdata_i[`APT_B_KIND], pwdata_i[3:0]};
    end
    if (wr && paddr_i == `APT_OFF_IMASK) begin
      imask_next = pwdata_i[2:0];
    end
    abort = wr && (paddr_i == `APT_OFF_CTRL || paddr_i == `APT_OFF_TRIG
      || paddr_i == `APT_OFF_START);
    start = wr && paddr_i == `APT_OFF_START && pwdata_i[`APT_B_START];
    halt = ctrl_reg.wait_mode_power_down & cpu_wait_i;
    // A trigger in the cycle of an aborting write is dropped, so the write always wins.
    // external trigger start
    ext_start = ctrl_reg.external_trigger_enable & fire & ~abort;
  end

  // Sequencer: the converter sees a held request and answers each conversion with a pulse.
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    done_cnt_next = done_cnt_reg;
    mem_wr = '0;
    seq_end = 1'b0;
    unique case (state_reg)
      seq_idle: begin
        if (start || ext_start) begin
          state_next = seq_conv;
        end
      end
      seq_conv: begin
        if (abort) begin
          state_next = start ? seq_conv : seq_idle;
        end else if (halt) begin
          state_next = seq_halt;
        end else if (conv_done_i) begin
          mem_wr = {1'b1, count_reg, conv_data_i};
          count_next = count_reg + 4'h1;
          done_cnt_next = done_cnt_reg + 4'h1;
          if (done_cnt_reg + 4'h1 == `APT_SEQ_LEN) begin
            seq_end = 1'b1;
            state_next = seq_idle;
          end
        end
      end
      seq_halt: begin
        // The converter loses its half-done sample, so resuming repeats the same slot.
        // resume after wait
        if (abort) begin
          state_next = start ? seq_conv : seq_idle;
        end else if (!halt) begin
          state_next = seq_conv;
        end
      end
      default: begin
        state_next = seq_idle;
      end
    endcase
    // counter reset on abort or start
    if (abort || start || (state_reg == seq_idle && ext_start)) begin
      count_next = 4'h0;
      done_cnt_next = 4'h0;
    end
    // Clearing the power bit drops any sequence; nothing resumes when power returns.
    // powered down holds idle
    if (!ctrl_reg.power_up) begin
      state_next = seq_idle;
    end
  end

  // Flags are cleared first and set last, so a result that lands in the cycle of a
  // clear is never lost to software.
  always_comb begin
    conv_flag_next = conv_flag_reg;
    armed_next = armed_reg;
    seq_done_next = seq_done_reg;
    if (rd && paddr_i == `APT_OFF_FLAGS) begin
      armed_next = 1'b1;
    end
    // One status read arms exactly one result read; the next result needs a new status read.
    if (done && res_hit) begin
      if (ctrl_reg.fast_flag_clear) begin
        conv_flag_next[res_idx] = 1'b0;
      end else if (rd && armed_reg) begin
        conv_flag_next[res_idx] = 1'b0;
        armed_next = 1'b0;
      end
    end
    if (start) begin
      conv_flag_next = 16'h0000;
    end
    if (abort || (wr && paddr_i == `APT_OFF_SEQ && pwdata_i[`APT_B_SEQ_DONE])) begin
      seq_done_next = 1'b0;
    end
    // A completing conversion wins over a clear in the same cycle.
    if (mem_wr.valid) begin
      conv_flag_next[mem_wr.slot] = 1'b1;
    end
    if (seq_end) begin
      seq_done_next = 1'b1;
    end
    events = 3'h0;
    events[`APT_IRQ_SEQ] = seq_end;
    events[`APT_IRQ_CONV] = mem_wr.valid;
    events[`APT_IRQ_ABORT] = abort && state_reg != seq_idle;
    ist_next = ist_reg;
    if (wr && paddr_i == `APT_OFF_IST) begin
      ist_next = ist_reg & ~pwdata_i[2:0];
    end
    ist_next = ist_next | events;
  end

  // Outputs register the next-state values, so each pin moves in the same cycle as the
  // state it reports instead of trailing it by one clock.
  always_comb begin
    power_next = ctrl_next.power_up & ~halt;
    req_next = state_next == seq_conv && !halt;
    slot_next = count_next;
    dien_next = 16'h0000;
    if (ctrl_next.external_trigger_enable
        && !(trig_next.trigger_source_kind_select & `APT_DEDICATED_AVAIL)) begin
      dien_next[trig_next.trigger_channel_select] = 1'b1;
    end
    irq_next = (ctrl_next.sequence_done_irq_enable & seq_done_next)
      | (|(ist_next & imask_next));
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      ctrl_reg <= `APT_CTRL_RST;
      trig_reg <= `APT_TRIG_RST;
      ist_reg <= `APT_IRQ_RST;
      imask_reg <= `APT_IRQ_RST;
      conv_flag_reg <= 16'h0000;
      seq_done_reg <= 1'b0;
      armed_reg <= 1'b0;
      state_reg <= seq_idle;
      count_reg <= 4'h0;
      done_cnt_reg <= 4'h0;
      analog_power_o <= 1'b0;
      conv_req_o <= 1'b0;
      conv_slot_o <= 4'h0;
      digital_input_enable_o <= 16'h0000;
      irq_o <= 1'b0;
    end else begin
      pready_o <= pready_next;
      pslverr_o <= pslverr_next;
      prdata_o <= prdata_next;
      ctrl_reg <= ctrl_next;
      trig_reg <= trig_next;
      ist_reg <= ist_next;
      imask_reg <= imask_next;
      conv_flag_reg <= conv_flag_next;
      seq_done_reg <= seq_done_next;
      armed_reg <= armed_next;
      state_reg <= state_next;
      count_reg <= count_next;
      done_cnt_reg <= done_cnt_next;
      analog_power_o <= power_next;
      conv_req_o <= req_next;
      conv_slot_o <= slot_next;
      digital_input_enable_o <= dien_next;
      irq_o <= irq_next;
    end
  end
endmodule

// *** apt_regs.svh ***
`ifndef APT_REGS_SVH
`define APT_REGS_SVH

// Register byte offsets on the APB.
`define APT_OFF_CTRL 8'h00
`define APT_OFF_TRIG 8'h04
`define APT_OFF_START 8'h08
`define APT_OFF_SEQ 8'h0C
`define APT_OFF_FLAGS 8'h10
`define APT_OFF_IST 8'h14
`define APT_OFF_IMASK 8'h18
`define APT_OFF_RES_BASE 8'h40

// Control register field positions.
`define APT_B_POWER_UP 7
`define APT_B_FAST_CLEAR 6
`define APT_B_WAIT_DOWN 5
`define APT_B_LEVEL 4
`define APT_B_POLARITY 3
`define APT_B_TRIG_EN 2
`define APT_B_SEQ_IE 1
`define APT_B_SEQ_FLAG 0

// Other field positions.
`define APT_B_KIND 7
`define APT_B_START 0
`define APT_B_SEQ_DONE 7

// Interrupt status bits.
`define APT_IRQ_SEQ 0
`define APT_IRQ_CONV 1
`define APT_IRQ_ABORT 2

// Reset values and counts.
`define APT_CTRL_RST 8'h00
`define APT_TRIG_RST 5'h00
`define APT_IRQ_RST 3'h0
`define APT_SEQ_LEN 4'h4
`define APT_DEDICATED_AVAIL 1'b1

`endif

// *** apt_pkg.sv ***
package apt_pkg;

  typedef struct packed {
    logic power_up;
    logic fast_flag_clear;
    logic wait_mode_power_down;
    logic trigger_level_not_edge;
    logic trigger_polarity;
    logic external_trigger_enable;
    logic sequence_done_irq_enable;
    logic flag_placeholder;
  } apt_ctrl_s;

  typedef struct packed {
    logic trigger_source_kind_select;
    logic [3:0] trigger_channel_select;
  } apt_trig_sel_s;

  typedef struct packed {
    logic valid;
    logic [3:0] slot;
    logic [9:0] data;
  } apt_conv_res_s;

  typedef enum logic [1:0] {seq_idle, seq_conv, seq_halt} apt_seq_e;

  function automatic logic apt_is_result(input logic [7:0] addr);
    return addr[7:6] == 2'h1;
  endfunction

endpackage

// *** apt_result_mem.sv ***
module apt_result_mem (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Write port
  input wire apt_pkg::apt_conv_res_s wr_i,
  // Read port
  input wire logic [3:0] rd_addr_i,
  output logic [9:0] rd_data_o
);
  import apt_pkg::*;

  logic [9:0] mem_reg [16];
  logic [9:0] rd_data_next;

  always_comb begin
    rd_data_next = mem_reg[rd_addr_i];
  end

  always_ff @(posedge clock_i) begin
    if (wr_i.valid) begin
      mem_reg[wr_i.slot] <= wr_i.data;
    end
    if (rst_i) begin
      rd_data_o <= 10'h000;
    end else begin
      rd_data_o <= rd_data_next;
    end
  end
endmodule

// *** apt_trigger.sv ***
`include "apt_regs.svh"
module apt_trigger (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Configuration
  input wire apt_pkg::apt_trig_sel_s sel_i,
  input wire logic level_i,
  input wire logic polarity_i,
  // Sources
  input wire logic [15:0] analog_pin_i,
  input wire logic [3:0] dedicated_trigger_i,
  // Result
  output logic fire_o
);
  import apt_pkg::*;

  logic src;
  logic prev_reg;
  logic prev_next;
  logic kind;

  always_comb begin
    kind = sel_i.trigger_source_kind_select & `APT_DEDICATED_AVAIL;
    if (!kind) begin
      src = analog_pin_i[sel_i.trigger_channel_select];
    end else if (sel_i.trigger_channel_select[3:2] == 2'h0) begin
      src = dedicated_trigger_i[sel_i.trigger_channel_select[1:0]];
    end else begin
      src = 1'b0;
    end
    prev_next = src;
    if (level_i) begin
      fire_o = (src == polarity_i);
    end else if (polarity_i) begin
      fire_o = src & ~prev_reg;
    end else begin
      fire_o = ~src & prev_reg;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
    end
  end
endmodule

// *** apt_ctrl_asserts.sv ***
`include "apt_regs.svh"
module apt_ctrl_asserts (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Converter and triggers
  input wire logic analog_power_o,
  input wire logic conv_req_o,
  input wire logic [3:0] conv_slot_o,
  input wire logic conv_done_i,
  input wire logic cpu_wait_i,
  input wire logic [15:0] digital_input_enable_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic ctrl_wr;
  assign ctrl_wr = psel_i && penable_i && pready_o && pwrite_i && paddr_i == `APT_OFF_CTRL;
  AST_WAIT_STATE: assert property (psel_i && penable_i && !pready_o |=> pready_o && psel_i)
    else $error("pready late");
  AST_ERR_WITH_READY: assert property (pslverr_o |-> pready_o && psel_i && penable_i)
    else $error("pslverr outside access");
  AST_ABORT_REQ: assert property (ctrl_wr |-> ##[1:2] !conv_req_o)
    else $error("no abort on control write");
  AST_ABORT_SLOT: assert property (ctrl_wr |-> ##[1:2] conv_slot_o == 4'h0)
    else $error("counter kept on control write");
  AST_POWER_BIT: assert property (ctrl_wr && !pwdata_i[`APT_B_POWER_UP] |-> ##[1:2] !analog_power_o)
    else $error("power stays on");
  AST_FLAG_GATED: assert property (pready_o && !pwrite_i && paddr_i == `APT_OFF_CTRL
    && !prdata_o[`APT_B_SEQ_IE] |-> !prdata_o[`APT_B_SEQ_FLAG])
    else $error("flag read while disabled");
  AST_SEQ_END: assert property (conv_req_o && conv_done_i && conv_slot_o == 4'h3 |=> !conv_req_o)
    else $error("sequence overran");
  AST_SLOT_STEP: assert property (conv_req_o && analog_power_o && !cpu_wait_i && !psel_i
    && conv_done_i && conv_slot_o != 4'h3 |=> conv_slot_o == $past(conv_slot_o) + 4'h1)
    else $error("counter did not step");
  AST_HALT: assert property (!analog_power_o [*2] |-> !conv_req_o)
    else $error("request while powered down");
  AST_BUF_ONEHOT: assert property ($onehot0(digital_input_enable_o))
    else $error("several buffers enabled");
endmodule

// *** apt_conv_model.sv ***
module apt_conv_model #(parameter int DLY = 4) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Request from the block
  input wire logic req_i,
  input wire logic power_i,
  input wire logic [3:0] slot_i,
  // Answer
  output logic done_o,
  output logic [9:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // recovery wait
  // The count restarts whenever power drops, so results after power-up come late.
  always_ff @(posedge clock_i) begin
    done_o <= 1'b0;
    data_o <= ~data_o;
    if (rst_i || !req_i || !power_i || done_o) begin
      cnt <= 0;
    end else if (cnt == DLY + 2 * slot_i) begin
      done_o <= 1'b1;
      data_o <= {6'h2A, slot_i};
    end else begin
      cnt <= cnt + 1;
    end
    if (rst_i) begin
      data_o <= 10'h155;
    end
  end
endmodule

// *** tb.sv ***
`include "apt_regs.svh"
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin error_cnt++; \
  $display("Error %s exp %0h got %0h", n, e, s); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic cpu_wait_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [15:0] analog_pin_i = 16'h0;
  logic [3:0] dedicated_trigger_i = 4'h0;
  logic [31:0] prdata_o, rdat;
  logic pready_o, pslverr_o, analog_power_o, conv_req_o, conv_done_i, irq_o, rerr;
  logic [3:0] conv_slot_o, s;
  logic [9:0] conv_data_i;
  logic [15:0] digital_input_enable_o;
  int error_cnt = 0;
  int n_compared = 0;

  always #50 clock_i = ~clock_i;

  apt_ctrl dut (.clock_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .analog_power_o, .conv_req_o, .conv_slot_o,
    .conv_done_i, .conv_data_i, .cpu_wait_i, .analog_pin_i, .dedicated_trigger_i,
    .digital_input_enable_o, .irq_o);
  apt_conv_model cm (.clock_i, .rst_i, .req_i(conv_req_o), .power_i(analog_power_o),
    .slot_i(conv_slot_o), .done_o(conv_done_i), .data_o(conv_data_i));

  // The request is released one edge after pready, so a new call never collides with it.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    `CHK(n, e, rdat)
  endtask
  task wreq(input logic v);
    for (int i = 0; i < 400 && conv_req_o !== v; i++) @(posedge clock_i);
  endtask
  task seq;
    wr(`APT_OFF_START, 32'h1);
    wreq(1'b1);
    wreq(1'b0);
    repeat (2) @(posedge clock_i);
  endtask
  task pins(input logic v);
    analog_pin_i <= {16{v}};
    dedicated_trigger_i <= {4{v}};
  endtask

  task t_regs;
    rdc(`APT_OFF_CTRL, 32'h0, "ctrl reset");
    apb(1'b0, 8'h20, 32'hFFFFFFFF);
    `CHK("unmapped", 1'b1, rerr)
    `CHK("unmapped data", 32'h0, rdat)
    wr(`APT_OFF_CTRL, 32'h07);
    rdc(`APT_OFF_CTRL, 32'h06, "flag write");
    `CHK("buffer ch0", 16'h0001, digital_input_enable_o)
    wr(`APT_OFF_TRIG, 32'h09);
    repeat (2) @(posedge clock_i);
    `CHK("buffer ch9", 16'h0200, digital_input_enable_o)
    wr(`APT_OFF_TRIG, 32'h83);
    repeat (2) @(posedge clock_i);
    `CHK("buffer off", 16'h0, digital_input_enable_o)
  endtask
  task t_seq;
    wr(`APT_OFF_CTRL, 32'h82);
    repeat (20) @(posedge clock_i);
    seq;
    `CHK("irq on", 1'b1, irq_o)
    rdc(`APT_OFF_CTRL, 32'h83, "flag read");
    rdc(`APT_OFF_FLAGS, 32'h0F, "flags");
    rdc(`APT_OFF_RES_BASE, 32'h2A0, "res0");
    rdc(`APT_OFF_RES_BASE + 8'h04, 32'h2A1, "res1");
    rdc(`APT_OFF_FLAGS, 32'h0E, "unarmed");
    rdc(`APT_OFF_RES_BASE + 8'h04, 32'h2A1, "res1");
    rdc(`APT_OFF_FLAGS, 32'h0C, "armed");
    wr(`APT_OFF_SEQ, 32'h80);
    repeat (2) @(posedge clock_i);
    `CHK("irq off", 1'b0, irq_o)
  endtask
  task t_mask;
    wr(`APT_OFF_CTRL, 32'h80);
    seq;
    `CHK("irq disabled", 1'b0, irq_o)
    rdc(`APT_OFF_IST, 32'h3, "ist");
    wr(`APT_OFF_IMASK, 32'h1);
    repeat (2) @(posedge clock_i);
    `CHK("irq masked in", 1'b1, irq_o)
    wr(`APT_OFF_IST, 32'h7);
    repeat (2) @(posedge clock_i);
    `CHK("irq cleared", 1'b0, irq_o)
    wr(`APT_OFF_IMASK, 32'h0);
  endtask
  task t_fast;
    wr(`APT_OFF_CTRL, 32'hC0);
    seq;
    rdc(`APT_OFF_RES_BASE + 8'h08, 32'h2A2, "res2");
    rdc(`APT_OFF_FLAGS, 32'h0B, "fast");
  endtask
  task t_abort;
    wr(`APT_OFF_START, 32'h1);
    for (int i = 0; i < 400 && conv_slot_o !== 4'h2; i++) @(posedge clock_i);
    wr(`APT_OFF_CTRL, 32'h80);
    repeat (10) @(posedge clock_i);
    `CHK("aborted", 1'b0, conv_req_o)
    rdc(`APT_OFF_SEQ, 32'h0, "counter");
    rdc(`APT_OFF_IST, 32'h7, "abort ist");
    wr(`APT_OFF_IST, 32'h7);
  endtask
  task t_wait;
    wr(`APT_OFF_CTRL, 32'hA0);
    wr(`APT_OFF_START, 32'h1);
    wreq(1'b1);
    cpu_wait_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    `CHK("wait power", 1'b0, analog_power_o)
    `CHK("wait halt", 1'b0, conv_req_o)
    s = conv_slot_o;
    cpu_wait_i <= 1'b0;
    wreq(1'b1);
    `CHK("resume", s, conv_slot_o)
    wreq(1'b0);
    wr(`APT_OFF_CTRL, 32'h80);
    cpu_wait_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    `CHK("wait run", 1'b1, analog_power_o)
    cpu_wait_i <= 1'b0;
  endtask
  task t_trig;
    logic [7:0] m;
    for (int i = 0; i < 4; i++) begin
      m = 8'(i << 3);
      pins(~m[3]);
      wr(`APT_OFF_TRIG, i[0] ? 32'h83 : 32'h09);
      wr(`APT_OFF_CTRL, 32'h80 | m);
      pins(m[3]);
      repeat (8) @(posedge clock_i);
      `CHK("trig disabled", 1'b0, conv_req_o)
      pins(~m[3]);
      wr(`APT_OFF_CTRL, 32'h84 | m);
      repeat (8) @(posedge clock_i);
      `CHK("trig idle", 1'b0, conv_req_o)
      pins(m[3]);
      wreq(1'b1);
      `CHK("trig fired", 1'b1, conv_req_o)
      pins(~m[3]);
      wreq(1'b0);
    end
  endtask

  task test_done;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    t_regs;
    $display("regs end");
    t_seq;
    $display("seq end");
    t_mask;
    $display("mask end");
    t_fast;
    $display("fast end");
    t_abort;
    $display("abort end");
    t_wait;
    $display("wait end");
    t_trig;
    $display("trig end");
    test_done;
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    error_cnt++;
    test_done;
  end
endmodule
bind apt_ctrl apt_ctrl_asserts ast (.clock_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .analog_power_o, .conv_req_o,
  .conv_slot_o, .conv_done_i, .cpu_wait_i, .digital_input_enable_o);
